// ==== pkg/flash_cmd_pkg.sv ====
// Constants, encodings and types shared by the serial flash command block.
`default_nettype none
package flash_cmd_pkg;

	// ------------------------------------------------------------------
	// Clock and self-timed cycle durations
	// ------------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS      = 20;
	localparam int STATUS_WRITE_TIME_US = 10;
	localparam int MODE_SWITCH_TIME_US  = 20;
	localparam int NS_PER_US            = 1000;
	localparam int STATUS_WRITE_CYCLES  = (STATUS_WRITE_TIME_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int MODE_SWITCH_CYCLES   = (MODE_SWITCH_TIME_US * NS_PER_US + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TIMER_W              = 16;

	// ------------------------------------------------------------------
	// Command codes (values are arbitrary)
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_ENABLE = 8'h10;
	localparam logic [7:0] CMD_WRITE_STATUS = 8'h11;
	localparam logic [7:0] CMD_READ_STATUS  = 8'h12;
	localparam logic [7:0] CMD_READ_CONFIG  = 8'h13;
	localparam logic [7:0] CMD_READ_ARRAY   = 8'h14;

	// ------------------------------------------------------------------
	// Status and configuration byte layout
	// ------------------------------------------------------------------
	localparam int SR_SWD    = 7;
	localparam int SR_QE     = 6;
	localparam int SR_BP_HI  = 5;
	localparam int SR_BP_LO  = 2;
	localparam int SR_WEL    = 1;
	localparam int SR_WIP    = 0;
	localparam int CFG1_DC   = 6;
	localparam int CFG1_TB   = 3;
	localparam int CFG2_LH   = 1;
	localparam int BP_W      = 4;

	localparam logic            RESET_SWD   = 1'b0;
	localparam logic            RESET_QE    = 1'b0;
	localparam logic [BP_W-1:0] RESET_BP    = 4'h0;
	localparam logic            RESET_DC    = 1'b0;
	localparam logic            RESET_TB    = 1'b0;
	localparam logic            RESET_POWER = 1'b0;

	// ------------------------------------------------------------------
	// Dummy cycle counts
	// ------------------------------------------------------------------
	localparam logic [3:0] DUAL_DUMMY_DEFAULT = 4'h4;
	localparam logic [3:0] DUAL_DUMMY_ALT     = 4'h8;
	localparam logic [3:0] QUAD_DUMMY_DEFAULT = 4'h6;
	localparam logic [3:0] QUAD_DUMMY_ALT     = 4'ha;

	// ------------------------------------------------------------------
	// Array and bit counting
	// ------------------------------------------------------------------
	localparam int              ADDR_W     = 24;
	localparam int              ARRAY_AW   = 12;
	localparam int              ARRAY_DEPTH = 4096;
	localparam logic [ADDR_W-1:0] ARRAY_LAST = 24'h000fff;
	localparam logic [ADDR_W-1:0] ADDR_ONE   = 24'h000001;
	localparam logic [4:0]      CMD_LAST_BIT  = 5'h07;
	localparam logic [4:0]      ADDR_LAST_BIT = 5'h17;
	localparam logic [4:0]      BITS_ONE      = 5'h08;
	localparam logic [4:0]      BITS_TWO      = 5'h10;
	localparam logic [4:0]      BITS_THREE    = 5'h18;
	localparam logic [4:0]      BITS_OVER     = 5'h19;
	localparam logic [2:0]      OUT_LAST_BIT  = 3'h7;

	typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WRITE_ENABLE_CMD, ST_WRITE_IN, ST_DATA, ST_IGNORE} link_state_t;
	typedef enum logic [1:0] {SRC_STATUS, SRC_CONFIG, SRC_ARRAY} out_src_t;

endpackage
`default_nettype wire

// ==== hdl/self_timed_cycle.sv ====
// Down counter that times an internal self-timed write cycle.
`default_nettype none
module self_timed_cycle
	import flash_cmd_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               start,
	input  wire logic [TIMER_W-1:0] cycles,
	output logic                    busy,
	output logic                    done
);

	logic [TIMER_W-1:0] count_q;

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	// Busy stands for exactly the loaded number of clocks, then done pulses once.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			count_q <= '0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_q <= cycles;
				busy    <= 1'b1;
			end else if (busy) begin
				count_q <= count_q - {{(TIMER_W-1){1'b0}}, 1'b1};
				if (count_q <= {{(TIMER_W-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ==== hdl/serial_flash_status_write_and_read.sv ====
// Serial flash command interpreter: status/config writes, protection modes and array read.
//
// How it works
// - Config byte two bit1 selects power mode.
// - Dummy select picks 4/8 dual, 6/10 quad.
// - Status write needs write enable latch set.
// - Status write keeps latch and busy bits.
// - Execute only at 8, 16, 24 bits.
// - Timed cycle starts when select rises.
// - Busy reads one; end clears busy, latch.
// - Status stays readable during timed cycle.
// - Hardware lock refuses status writes.
// - Writes allowed unless disable set, pin low.
// - Disable set, pin low rejects every status write.
// - Disable set with pin low gives lock.
// - Lock ends only when pin goes high.
// - Protected area refused in both lock modes.
// - Sample on rising clock, shift out falling.
// - Address advances one after each byte.
// - Address wraps to zero past the end.
// - Status byte bit layout as listed.
// - Dummy select is config byte one bit6.
`default_nettype none
module serial_flash_status_write_and_read
	import flash_cmd_pkg::*;
(
	input  wire logic                clock,
	input  wire logic                rst,
	input  wire logic                cs_n,
	input  wire logic                sclk,
	input  wire logic                si,
	input  wire logic                write_protect_pin,
	input  wire logic                load_valid,
	input  wire logic [ARRAY_AW-1:0] load_addr,
	input  wire logic [7:0]          load_data,
	output logic                     so,
	output logic                     so_oe,
	output logic                     power_performance_select,
	output logic [3:0]               dual_dummy_cycles,
	output logic [3:0]               quad_dummy_cycles,
	output logic                     hardware_lock_mode,
	output logic                     software_lock_mode,
	output logic [BP_W-1:0]          protect_level,
	output logic                     quad_enable
);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	logic [2:0]  cs_sync_q;
	logic [2:0]  sclk_sync_q;
	logic [2:0]  si_sync_q;
	logic [2:0]  wp_sync_q;
	logic        cs_lvl_q;
	logic        sclk_lvl_q;
	logic        si_lvl_q;
	logic        wp_lvl_q;

	// A level is accepted once the second and third stages agree.
	function automatic logic settle(input logic [2:0] sync, input logic lvl);
		settle = (sync[1] == sync[2]) ? sync[2] : lvl;
	endfunction

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_sync_q   <= 3'h7;
			sclk_sync_q <= 3'h0;
			si_sync_q   <= 3'h0;
			wp_sync_q   <= 3'h7;
			cs_lvl_q    <= 1'b1;
			sclk_lvl_q  <= 1'b0;
			si_lvl_q    <= 1'b0;
			wp_lvl_q    <= 1'b1;
		end else begin
			cs_sync_q   <= {cs_sync_q[1:0], cs_n};
			sclk_sync_q <= {sclk_sync_q[1:0], sclk};
			si_sync_q   <= {si_sync_q[1:0], si};
			wp_sync_q   <= {wp_sync_q[1:0], write_protect_pin};
			cs_lvl_q    <= settle(cs_sync_q, cs_lvl_q);
			sclk_lvl_q  <= settle(sclk_sync_q, sclk_lvl_q);
			si_lvl_q    <= settle(si_sync_q, si_lvl_q);
			wp_lvl_q    <= settle(wp_sync_q, wp_lvl_q);
		end
	end

	logic cs_next;
	logic sclk_next;
	logic si_next;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic selected;

	assign cs_next   = settle(cs_sync_q, cs_lvl_q);
	assign sclk_next = settle(sclk_sync_q, sclk_lvl_q);
	assign si_next   = settle(si_sync_q, si_lvl_q);
	assign cs_rise   = cs_next & ~cs_lvl_q;
	assign selected  = ~cs_lvl_q & ~cs_next;
	assign sclk_rise = selected & sclk_next & ~sclk_lvl_q;
	assign sclk_fall = selected & ~sclk_next & sclk_lvl_q;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic              swd_q;
	logic              qe_q;
	logic [BP_W-1:0]   bp_q;
	logic              wel_q;
	logic              dc_q;
	logic              tb_q;
	logic              lh_q;
	logic              busy;
	logic              cycle_done;
	logic              hw_lock_now;
	logic [7:0]        status_byte;
	logic [7:0]        config1_byte;
	logic [7:0]        config2_byte;

	assign hw_lock_now  = swd_q & ~wp_lvl_q;
	assign status_byte  = {swd_q, qe_q, bp_q, wel_q, busy};
	assign config1_byte = {1'b0, dc_q, 2'b00, tb_q, 3'b000};
	assign config2_byte = {6'b000000, lh_q, 1'b0};

	// ------------------------------------------------------------------
	// Link sequencer
	// ------------------------------------------------------------------
	link_state_t       state_q;
	out_src_t          src_q;
	logic [4:0]        bit_cnt_q;
	logic [7:0]        cmd_q;
	logic [ADDR_W-1:0] addr_q;
	logic [23:0]       wr_buf_q;
	logic [4:0]        data_cnt_q;
	logic [7:0]        cmd_full;

	assign cmd_full = {cmd_q[6:0], si_next};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q    <= ST_CMD;
			src_q      <= SRC_STATUS;
			bit_cnt_q  <= '0;
			cmd_q      <= '0;
			wr_buf_q   <= '0;
			data_cnt_q <= '0;
		end else if (cs_rise) begin
			state_q    <= ST_CMD;
			bit_cnt_q  <= '0;
			data_cnt_q <= '0;
		end else if (sclk_rise) begin
			case (state_q)
				ST_CMD: begin
					cmd_q     <= cmd_full;
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == CMD_LAST_BIT) begin
						bit_cnt_q <= '0;
						state_q   <= ST_IGNORE;
						case (cmd_full)
							CMD_WRITE_ENABLE: if (!busy) state_q <= ST_WRITE_ENABLE_CMD;
							CMD_WRITE_STATUS: if (!busy) state_q <= ST_WRITE_IN;
							CMD_READ_STATUS: begin
								state_q <= ST_DATA;
								src_q   <= SRC_STATUS;
							end
							CMD_READ_CONFIG: begin
								state_q <= ST_DATA;
								src_q   <= SRC_CONFIG;
							end
							CMD_READ_ARRAY: if (!busy) state_q <= ST_ADDR;
							default: state_q <= ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					bit_cnt_q <= bit_cnt_q + 5'h01;
					if (bit_cnt_q == ADDR_LAST_BIT) begin
						state_q <= ST_DATA;
						src_q   <= SRC_ARRAY;
					end
				end
				ST_WRITE_ENABLE_CMD: state_q <= ST_IGNORE;
				ST_WRITE_IN: begin
					wr_buf_q <= {wr_buf_q[22:0], si_next};
					if (data_cnt_q != BITS_OVER) begin
						data_cnt_q <= data_cnt_q + 5'h01;
					end
				end
				ST_DATA: state_q <= ST_DATA;
				ST_IGNORE: state_q <= ST_IGNORE;
				default: state_q <= ST_IGNORE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Read address and array
	// ------------------------------------------------------------------
	logic [7:0] mem [0:ARRAY_DEPTH-1];
	logic [2:0] out_cnt_q;
	logic       out_load;

	assign out_load = sclk_fall && (state_q == ST_DATA) && (out_cnt_q == 3'h0);

	always_ff @(posedge clock) begin
		if (load_valid) begin
			mem[load_addr] <= load_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			addr_q <= '0;
		end else if (sclk_rise && state_q == ST_ADDR) begin
			addr_q <= {addr_q[ADDR_W-2:0], si_next};
		end else if (out_load && src_q == SRC_ARRAY) begin
			addr_q <= (addr_q == ARRAY_LAST) ? '0 : addr_q + ADDR_ONE;
		end
	end

	// ------------------------------------------------------------------
	// Serial output shifter
	// ------------------------------------------------------------------
	logic [7:0] out_shift_q;
	logic       cfg_sel_q;
	logic [7:0] next_byte;

	always_comb begin
		case (src_q)
			SRC_STATUS: next_byte = status_byte;
			SRC_CONFIG: next_byte = cfg_sel_q ? config2_byte : config1_byte;
			SRC_ARRAY:  next_byte = mem[addr_q[ARRAY_AW-1:0]];
			default:    next_byte = status_byte;
		endcase
	end

	// Bits leave on falling clock edges; the line is released when select rises.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			so          <= 1'b0;
			so_oe       <= 1'b0;
			out_shift_q <= '0;
			out_cnt_q   <= '0;
			cfg_sel_q   <= 1'b0;
		end else if (cs_rise) begin
			so_oe     <= 1'b0;
			out_cnt_q <= '0;
			cfg_sel_q <= 1'b0;
		end else if (sclk_fall && state_q == ST_DATA) begin
			so_oe     <= 1'b1;
			out_cnt_q <= (out_cnt_q == OUT_LAST_BIT) ? 3'h0 : out_cnt_q + 3'h1;
			if (out_cnt_q == 3'h0) begin
				so          <= next_byte[7];
				out_shift_q <= {next_byte[6:0], 1'b0};
				if (src_q == SRC_CONFIG) begin
					cfg_sel_q <= ~cfg_sel_q;
				end
			end else begin
				so          <= out_shift_q[7];
				out_shift_q <= {out_shift_q[6:0], 1'b0};
			end
		end
	end

	// ------------------------------------------------------------------
	// Status write decision
	// ------------------------------------------------------------------
	logic            len_ok;
	logic            write_go;
	logic            have_cfg1;
	logic            have_cfg2;
	logic [7:0]      new_status;
	logic [7:0]      new_cfg1;
	logic [7:0]      new_cfg2;
	logic            lh_next;
	logic [TIMER_W-1:0] cycle_len;

	always_comb begin
		len_ok     = 1'b0;
		have_cfg1  = 1'b0;
		have_cfg2  = 1'b0;
		new_status = status_byte;
		new_cfg1   = config1_byte;
		new_cfg2   = config2_byte;
		case (data_cnt_q)
			BITS_ONE: begin
				len_ok     = 1'b1;
				new_status = wr_buf_q[7:0];
			end
			BITS_TWO: begin
				len_ok     = 1'b1;
				have_cfg1  = 1'b1;
				new_status = wr_buf_q[15:8];
				new_cfg1   = wr_buf_q[7:0];
			end
			BITS_THREE: begin
				len_ok     = 1'b1;
				have_cfg1  = 1'b1;
				have_cfg2  = 1'b1;
				new_status = wr_buf_q[23:16];
				new_cfg1   = wr_buf_q[15:8];
				new_cfg2   = wr_buf_q[7:0];
			end
			default: len_ok = 1'b0;
		endcase
	end

	// Refused while the lock holds, without the latch, or mid-cycle.
	assign write_go  = cs_rise && state_q == ST_WRITE_IN && len_ok && wel_q && !hw_lock_now && !busy;
	assign lh_next   = have_cfg2 ? new_cfg2[CFG2_LH] : lh_q;
	assign cycle_len = (lh_next != lh_q) ? TIMER_W'(MODE_SWITCH_CYCLES) : TIMER_W'(STATUS_WRITE_CYCLES);

	self_timed_cycle u_cycle (
		.clock  (clock),
		.rst    (rst),
		.start  (write_go),
		.cycles (cycle_len),
		.busy   (busy),
		.done   (cycle_done)
	);

	// ------------------------------------------------------------------
	// Status and configuration registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			swd_q <= RESET_SWD;
			qe_q  <= RESET_QE;
			bp_q  <= RESET_BP;
			dc_q  <= RESET_DC;
			tb_q  <= RESET_TB;
			lh_q  <= RESET_POWER;
		end else if (write_go) begin
			swd_q <= new_status[SR_SWD];
			qe_q  <= new_status[SR_QE];
			bp_q  <= new_status[SR_BP_HI:SR_BP_LO];
			if (have_cfg1) begin
				dc_q <= new_cfg1[CFG1_DC];
				tb_q <= tb_q | new_cfg1[CFG1_TB];
			end
			lh_q <= lh_next;
		end
	end

	// The latch is set only by the enable command and cleared when a cycle ends.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wel_q <= 1'b0;
		end else if (cs_rise && state_q == ST_WRITE_ENABLE_CMD && !busy) begin
			wel_q <= 1'b1;
		end else if (cycle_done) begin
			wel_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Mode outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			power_performance_select <= RESET_POWER;
			dual_dummy_cycles        <= DUAL_DUMMY_DEFAULT;
			quad_dummy_cycles        <= QUAD_DUMMY_DEFAULT;
			quad_enable              <= RESET_QE;
		end else begin
			power_performance_select <= lh_q;
			dual_dummy_cycles        <= dc_q ? DUAL_DUMMY_ALT : DUAL_DUMMY_DEFAULT;
			quad_dummy_cycles        <= dc_q ? QUAD_DUMMY_ALT : QUAD_DUMMY_DEFAULT;
			quad_enable              <= qe_q;
		end
	end

	// Program and erase of the protect_level area are refused in either lock mode.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hardware_lock_mode <= 1'b0;
			software_lock_mode <= 1'b1;
			protect_level      <= RESET_BP;
		end else begin
			hardware_lock_mode <= hw_lock_now;
			software_lock_mode <= ~hw_lock_now;
			protect_level      <= bp_q;
		end
	end

endmodule
`default_nettype wire

// ==== bench/flash_status_monitor.sv ====
// Port-level checker for the serial flash command block.
`default_nettype none
module flash_status_monitor
	import flash_cmd_pkg::*;
(
	input wire logic            clock,
	input wire logic            rst,
	input wire logic            cs_n,
	input wire logic            sclk,
	input wire logic            write_protect_pin,
	input wire logic            so,
	input wire logic            so_oe,
	input wire logic            power_performance_select,
	input wire logic [3:0]      dual_dummy_cycles,
	input wire logic [3:0]      quad_dummy_cycles,
	input wire logic            hardware_lock_mode,
	input wire logic            software_lock_mode,
	input wire logic [BP_W-1:0] protect_level,
	input wire logic            quad_enable
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	lock_modes_complement_a: assert property (
		software_lock_mode == !hardware_lock_mode) else $error("lock mode outputs not complementary");
	pin_high_unlocks_a: assert property (
		write_protect_pin [*6] |-> !hardware_lock_mode) else $error("lock held with protect pin high");
	dummy_pair_legal_a: assert property (
		(dual_dummy_cycles == DUAL_DUMMY_DEFAULT && quad_dummy_cycles == QUAD_DUMMY_DEFAULT) ||
		(dual_dummy_cycles == DUAL_DUMMY_ALT && quad_dummy_cycles == QUAD_DUMMY_ALT))
		else $error("dummy cycle counts inconsistent");
	out_bit_hold_a: assert property (
		sclk [*3] |=> $stable(so)) else $error("serial output moved while serial clock high");
	write_at_select_rise_a: assert property (
		!cs_n [*5] |=> $stable(protect_level) && $stable(quad_enable) && $stable(power_performance_select)
		&& $stable(dual_dummy_cycles)) else $error("settings changed inside a frame");
	locked_level_frozen_a: assert property (
		hardware_lock_mode [*2] |=> $stable(protect_level)) else $error("protect level changed while locked");
	reset_values_a: assert property (
		$fell(rst) |-> !power_performance_select && protect_level == 4'h0 && !quad_enable && !so_oe
		&& software_lock_mode) else $error("wrong values after reset");
	oe_release_a: assert property (
		$rose(cs_n) |-> ##[1:6] !so_oe) else $error("output enable held after deselect");
endmodule

bind serial_flash_status_write_and_read flash_status_monitor u_flash_status_monitor (
	.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .write_protect_pin(write_protect_pin), .so(so),
	.so_oe(so_oe), .power_performance_select(power_performance_select), .dual_dummy_cycles(dual_dummy_cycles),
	.quad_dummy_cycles(quad_dummy_cycles), .hardware_lock_mode(hardware_lock_mode),
	.software_lock_mode(software_lock_mode), .protect_level(protect_level), .quad_enable(quad_enable));
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// Behavioural host controller that frames commands on the serial link.
`default_nettype none
module spi_host_model (
	input  wire logic clock,
	output logic      cs_n,
	output logic      sclk,
	output logic      si,
	input  wire logic so
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Sends a command byte and nbits more bits, capturing so just before each falling edge after the command byte.
	task automatic xfer(input logic [7:0] cmd, input logic [63:0] tx, input int nbits, output logic [63:0] rx);
		rx = '0;
		tick(1);
		cs_n = 1'b0;
		for (int i = 0; i < nbits + 8; i++) begin
			sclk = 1'b0;
			si = (i < 8) ? cmd[7 - i] : tx[nbits + 7 - i];
			tick(4);
			sclk = 1'b1;
			tick(4);
			if (i >= 8) begin
				rx = {rx[62:0], so};
			end
		end
		sclk = 1'b0;
		si = ~si;
		tick(4);
		cs_n = 1'b1;
		tick(10);
	endtask
endmodule
`default_nettype wire

// ==== bench/serial_flash_status_write_and_read_tb_top.sv ====
// Self-checking bench for the serial flash command block.
`default_nettype none
module serial_flash_status_write_and_read_tb_top import flash_cmd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                clock, rst, cs_n, sclk, si, so, so_oe, write_protect_pin, load_valid;
	logic [ARRAY_AW-1:0] load_addr;
	logic [7:0]          load_data;
	logic                power_performance_select, hardware_lock_mode, software_lock_mode, quad_enable;
	logic [3:0]          dual_dummy_cycles, quad_dummy_cycles;
	logic [BP_W-1:0]     protect_level;
	logic [63:0]         rx;
	int                  miscompares, cmp_count;

	always #10 clock = ~clock;

	serial_flash_status_write_and_read u_serial_flash_status_write_and_read (
		.clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si), .write_protect_pin(write_protect_pin),
		.load_valid(load_valid), .load_addr(load_addr), .load_data(load_data), .so(so), .so_oe(so_oe),
		.power_performance_select(power_performance_select), .dual_dummy_cycles(dual_dummy_cycles),
		.quad_dummy_cycles(quad_dummy_cycles), .hardware_lock_mode(hardware_lock_mode),
		.software_lock_mode(software_lock_mode), .protect_level(protect_level), .quad_enable(quad_enable));

	spi_host_model u_spi_host_model (.clock(clock), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so));

	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic expect_status(input logic [7:0] e);
		u_spi_host_model.xfer(CMD_READ_STATUS, 64'h0, 8, rx);
		check("status byte", rx, {56'h0, e});
	endtask

	task automatic write_enable_cmd();
		u_spi_host_model.xfer(CMD_WRITE_ENABLE, 64'h0, 0, rx);
	endtask

	task automatic write_status_cmd(input logic [23:0] d, input int nbits);
		u_spi_host_model.xfer(CMD_WRITE_STATUS, {40'h0, d}, nbits, rx);
	endtask

	// Polls the busy bit a bounded number of times.
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			u_spi_host_model.xfer(CMD_READ_STATUS, 64'h0, 8, rx);
			n++;
		end while (rx[0] !== 1'b0 && n < 40);
		check("busy cleared", {63'h0, rx[0]}, 64'h0);
	endtask

	task automatic preload(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		load_valid = 1'b1;
		load_addr = a;
		load_data = d;
		@(posedge clock);
		#1;
		load_valid = 1'b0;
	endtask

	task automatic settle();
		repeat (8) @(posedge clock);
		#1;
	endtask

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		write_protect_pin = 1'b1;
		load_valid = 1'b0;
		load_addr = '0;
		load_data = '0;
		miscompares = 0;
		cmp_count = 0;
		repeat (20) @(posedge clock);
		#1;
		rst = 1'b0;
		settle();
		check("reset outputs", {power_performance_select, dual_dummy_cycles, quad_dummy_cycles, hardware_lock_mode,
			software_lock_mode, protect_level, quad_enable, so_oe}, 17'h04640);
		expect_status(8'h00);
		write_status_cmd(24'h0000fc, 8);
		expect_status(8'h00);
		write_enable_cmd();
		expect_status(8'h02);
		write_status_cmd(24'h6bff02, 24);
		expect_status(8'h6b);
		check("settings applied", {quad_enable, dual_dummy_cycles, quad_dummy_cycles, protect_level,
			power_performance_select}, 14'h3155);
		u_spi_host_model.xfer(CMD_READ_CONFIG, 64'h0, 16, rx);
		check("config bytes", rx, 64'h4802);
		wait_idle();
		expect_status(8'h68);
		write_enable_cmd();
		write_status_cmd(24'h000abc, 12);
		expect_status(8'h6a);
		write_status_cmd(24'h000094, 8);
		expect_status(8'h97);
		check("unsent bytes kept", {dual_dummy_cycles, power_performance_select}, 5'h11);
		wait_idle();
		expect_status(8'h94);
		write_protect_pin = 1'b0;
		settle();
		check("lock entered", {hardware_lock_mode, software_lock_mode}, 2'b10);
		write_enable_cmd();
		write_status_cmd(24'h000000, 8);
		expect_status(8'h96);
		check("locked level", protect_level, 4'h5);
		write_protect_pin = 1'b1;
		settle();
		check("lock left", {hardware_lock_mode, software_lock_mode}, 2'b01);
		write_status_cmd(24'h000000, 8);
		wait_idle();
		expect_status(8'h00);
		preload(12'hffe, 8'h5a);
		preload(12'hfff, 8'hc3);
		preload(12'h000, 8'h81);
		u_spi_host_model.xfer(CMD_READ_ARRAY, {16'h0, 24'h000ffe, 24'h0}, 48, rx);
		check("array stream", rx[23:0], 24'h5ac381);
		report_and_stop();
	end

	initial begin
		#1ms;
		miscompares++;
		report_and_stop();
	end
endmodule
`default_nettype wire
